// [dv/wut_properties.sv]
module wut_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // interrupt
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic ar_go;
  logic map_hit;
  assign ar_go = s_axi_arvalid && s_axi_arready;
  assign map_hit = s_axi_araddr inside {wut_pkg::ADDR_CONTROL, wut_pkg::ADDR_VALUE,
    wut_pkg::ADDR_IRQ_STATUS, wut_pkg::ADDR_IRQ_MASK};
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  r_latency_a: assert property (ar_go |=> s_axi_rvalid)
    else $error("read data late");
  w_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  ctrl_zero_a: assert property (ar_go && s_axi_araddr == wut_pkg::ADDR_CONTROL |=>
    s_axi_rdata[31:2] == 30'h0) else $error("control reserved bits set");
  value_width_a: assert property (ar_go && s_axi_araddr == wut_pkg::ADDR_VALUE |=>
    s_axi_rdata[31:16] == 16'h0) else $error("value upper bits set");
  unmapped_a: assert property (ar_go && !map_hit |=>
    s_axi_rresp == wut_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  reset_quiet_a: assert property ($rose(arst_n) |-> !s_axi_bvalid && !s_axi_rvalid &&
    !irq) else $error("outputs active after reset");
  irq_c: cover property ($rose(irq));
  bad_read_c: cover property (ar_go && !map_hit);
  write_c: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind wut_top wut_checker chk_i (.clk_sys(clk_sys), .arst_n(arst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .irq(irq));

// [dv/wut_tb.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] s;} wut_row_t;
  logic clk_sys, arst_n, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r, irq;
  logic [7:0] aw_a, ar_a;
  logic [31:0] w_d, r_d, v, v_prev;
  logic [1:0] b_s, r_s, s;
  int error_cnt, total_checks, cyc, n;
  wut_row_t rows [5] = '{
    '{wut_pkg::ADDR_VALUE, 32'hFFFF1234, 32'h00001234, wut_pkg::RESP_OKAY},
    '{wut_pkg::ADDR_CONTROL, 32'h000000FE, 32'h00000000, wut_pkg::RESP_OKAY},
    '{wut_pkg::ADDR_IRQ_MASK, 32'h000000A5, 32'h000000A5, wut_pkg::RESP_OKAY},
    '{wut_pkg::ADDR_IRQ_STATUS, 32'h000000FF, 32'h00000000, wut_pkg::RESP_OKAY},
    '{8'h20, 32'h0000005A, 32'h00000000, wut_pkg::RESP_SLVERR}};

  wut_top uut (.clk_sys(clk_sys), .arst_n(arst_n),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
    .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_bresp(b_s),
    .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0),
    .s_axi_rvalid(r_v), .s_axi_rready(r_r), .s_axi_rdata(r_d), .s_axi_rresp(r_s),
    .irq(irq));

  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // address and data are released independently as each is taken
  // lag holds bready low for that many edges after the handshakes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int lag = 0);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk_sys);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= (lag == 0);
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      if (aw_r && !ad) begin
        ad = 1'b1;
        aw_v <= 1'b0;
      end
      if (w_r && !wd) begin
        wd = 1'b1;
        w_v <= 1'b0;
      end
    end
    repeat (lag) @(posedge clk_sys);
    b_r <= 1'b1;
    do @(posedge clk_sys); while (b_v !== 1'b1);
    s = b_s;
    b_r <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input int lag = 0);
    @(posedge clk_sys);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= (lag == 0);
    do @(posedge clk_sys); while (ar_r !== 1'b1);
    ar_v <= 1'b0;
    repeat (lag) @(posedge clk_sys);
    r_r <= 1'b1;
    do @(posedge clk_sys); while (r_v !== 1'b1);
    v = r_d;
    s = r_s;
    r_r <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input int lag = 0);
    rd(a, lag);
    chk($sformatf("reg %h", a), e, v);
  endtask
  // completion time bounds how many ring steps were taken
  task automatic wirq(input int lo, input int hi);
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    chk("irq delay in range", 32'h1, 32'(n >= lo && n <= hi));
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    {aw_v, w_v, b_r, ar_v, r_r} = 5'h00;
    aw_a = 8'h00;
    ar_a = 8'h00;
    w_d = 32'h0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rchk(wut_pkg::ADDR_CONTROL + 8'(4 * i), 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, i);
      chk("write resp", 32'(rows[i].s), 32'(s));
      rchk(rows[i].a, rows[i].e, i);
      chk("read resp", 32'(rows[i].s), 32'(s));
    end
    wr(wut_pkg::ADDR_VALUE, 32'h5);
    wr(wut_pkg::ADDR_CONTROL, 32'h1);
    wirq(35, 60);
    rchk(wut_pkg::ADDR_CONTROL, 32'h3);
    rchk(wut_pkg::ADDR_VALUE, 32'h0);
    rchk(wut_pkg::ADDR_IRQ_STATUS, 32'h1);
    wr(wut_pkg::ADDR_IRQ_MASK, 32'h0);
    chk("irq masked", 32'h0, 32'(irq));
    wr(wut_pkg::ADDR_IRQ_MASK, 32'h1);
    chk("irq unmasked", 32'h1, 32'(irq));
    wr(wut_pkg::ADDR_IRQ_STATUS, 32'h1);
    chk("irq cleared", 32'h0, 32'(irq));
    wr(wut_pkg::ADDR_CONTROL, 32'h0);
    rchk(wut_pkg::ADDR_CONTROL, 32'h0);
    rchk(wut_pkg::ADDR_VALUE, 32'h5);
    wr(wut_pkg::ADDR_VALUE, 32'hFFFF);
    wr(wut_pkg::ADDR_CONTROL, 32'h1);
    repeat (30) @(posedge clk_sys);
    rd(wut_pkg::ADDR_VALUE);
    chk("live count", 32'h1, 32'(v < 32'hFFFF && v > 32'hFFF0));
    wr(wut_pkg::ADDR_VALUE, 32'h7);
    rd(wut_pkg::ADDR_VALUE);
    chk("live after write", 32'h1, 32'(v < 32'hFFFF && v > 32'hFFF0));
    // the counter may step between two reads, so read until two agree
    do begin
      v_prev = v;
      rd(wut_pkg::ADDR_VALUE);
    end while (v !== v_prev);
    chk("reread agrees", 32'h1, 32'(v < 32'hFFFF && v > 32'hFFF0));
    wr(wut_pkg::ADDR_CONTROL, 32'h0);
    rchk(wut_pkg::ADDR_VALUE, 32'h7);
    wr(wut_pkg::ADDR_CONTROL, 32'h1);
    wirq(55, 85);
    wr(wut_pkg::ADDR_CONTROL, 32'h0);
    wr(wut_pkg::ADDR_CONTROL, 32'h1);
    rchk(wut_pkg::ADDR_CONTROL, 32'h1);
    arst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    rchk(wut_pkg::ADDR_VALUE, 32'h0);
    rchk(wut_pkg::ADDR_CONTROL, 32'h0);
    chk("irq after reset", 32'h0, 32'(irq));
    give_verdict();
  end
endmodule

// [src/wut_downcnt.sv]
module wut_downcnt (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // control
  input wire logic ring_tick,
  input wire logic run,
  input wire logic [15:0] start_value,
  // status
  output logic [15:0] count_q,
  output logic done_q
);

  wut_pkg::wut_state_t state_q;
  logic run_prev_q;
  logic at_last;

  assign at_last = (count_q == wut_pkg::COUNT_ONE) || (count_q == wut_pkg::VALUE_RST);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= run;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= wut_pkg::WUT_ST_IDLE;
      count_q <= wut_pkg::VALUE_RST;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!run) begin
        state_q <= wut_pkg::WUT_ST_IDLE;
        count_q <= wut_pkg::VALUE_RST;
      end else if (!run_prev_q) begin
        state_q <= wut_pkg::WUT_ST_RUN;
        count_q <= start_value;
      end else begin
        case (state_q)
          wut_pkg::WUT_ST_RUN: begin
            if (ring_tick) begin
              if (at_last) begin
                count_q <= wut_pkg::VALUE_RST;
                state_q <= wut_pkg::WUT_ST_ZERO;
                done_q <= 1'b1;
              end else begin
                count_q <= count_q - wut_pkg::COUNT_ONE;
              end
            end
          end
          wut_pkg::WUT_ST_ZERO: begin
            count_q <= wut_pkg::VALUE_RST;
          end
          wut_pkg::WUT_ST_IDLE: begin
            state_q <= wut_pkg::WUT_ST_IDLE;
          end
          default: begin
            state_q <= wut_pkg::WUT_ST_IDLE;
            count_q <= wut_pkg::VALUE_RST;
          end
        endcase
      end
    end
  end

endmodule

// [src/wut_pkg.sv]
package wut_pkg;

  // ------------------------------------------------------------
  // clock and ring oscillator timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  // ring oscillator period, modelled as an enable from a divider
  localparam int unsigned RING_PERIOD_NS = 1000;
  localparam int unsigned RING_TICK_CYCLES =
    (RING_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RING_TICK_LAST = 8'(RING_TICK_CYCLES - 1);

  // ------------------------------------------------------------
  // register map: printed offsets are indices, byte address is 4x
  // ------------------------------------------------------------
  localparam logic [5:0] IDX_CONTROL = 6'h04;
  localparam logic [5:0] IDX_VALUE = 6'h05;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h06;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h07;
  localparam logic [7:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
  localparam logic [7:0] ADDR_VALUE = {IDX_VALUE, 2'h0};
  localparam logic [7:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
  localparam logic [7:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_DONE_BIT = 1;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // down-counter states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    WUT_ST_IDLE = 3'h1,
    WUT_ST_RUN = 3'h2,
    WUT_ST_ZERO = 3'h4
  } wut_state_t;

endpackage

// [src/wut_top.sv]
// Design decision made here: register access over AXI4-Lite.
module wut_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [7:0] ring_div_q;
  logic ring_tick_q;
  logic aw_have_q;
  logic [7:0] aw_addr_q;
  logic w_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_commit;
  logic wr_hit_ctrl;
  logic wr_hit_value;
  logic wr_hit_status;
  logic wr_hit_mask;
  logic wr_mapped;
  logic ar_take;
  logic run_q;
  logic run_d;
  logic run_change;
  logic [15:0] start_q;
  logic done_flag_q;
  logic [15:0] count_live;
  logic count_done;
  logic [15:0] count_view_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_mask_q;
  logic [7:0] irq_set;
  logic [7:0] ctrl_rd;
  logic [15:0] value_rd;
  logic [31:0] rd_word;
  logic rd_mapped;

  // ------------------------------------------------------------
  // ring oscillator rate
  // ------------------------------------------------------------
  // a one-cycle enable keeps the counter on the system clock and avoids
  // a second domain, at the price of a ring rate tied to the divider
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ring_div_q <= 8'h00;
      ring_tick_q <= 1'b0;
    end else if (ring_div_q == wut_pkg::RING_TICK_LAST) begin
      ring_div_q <= 8'h00;
      ring_tick_q <= 1'b1;
    end else begin
      ring_div_q <= ring_div_q + 8'h01;
      ring_tick_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // write address and data capture
  // ------------------------------------------------------------
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign wr_commit = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_commit) begin
      w_have_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // write decode and response
  // ------------------------------------------------------------
  assign wr_hit_ctrl = wr_commit && (aw_addr_q == wut_pkg::ADDR_CONTROL);
  assign wr_hit_value = wr_commit && (aw_addr_q == wut_pkg::ADDR_VALUE);
  assign wr_hit_status = wr_commit && (aw_addr_q == wut_pkg::ADDR_IRQ_STATUS);
  assign wr_hit_mask = wr_commit && (aw_addr_q == wut_pkg::ADDR_IRQ_MASK);
  assign wr_mapped = wr_hit_ctrl || wr_hit_value || wr_hit_status || wr_hit_mask;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= wut_pkg::RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? wut_pkg::RESP_OKAY : wut_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ------------------------------------------------------------
  // control register: run enable
  // ------------------------------------------------------------
  // the done flag is hardware owned; a written value on its bit is dropped
  always_comb begin
    run_d = run_q;
    if (wr_hit_ctrl && w_strb_q[0]) begin
      run_d = w_data_q[wut_pkg::CTRL_RUN_BIT];
    end
  end

  assign run_change = run_d != run_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  // ------------------------------------------------------------
  // stored start value
  // ------------------------------------------------------------
  // writes always land here, running or not, so the next arm reuses it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= wut_pkg::VALUE_RST;
    end else if (wr_hit_value) begin
      if (w_strb_q[0]) begin
        start_q[7:0] <= w_data_q[7:0];
      end
      if (w_strb_q[1]) begin
        start_q[15:8] <= w_data_q[15:8];
      end
    end
  end

  // ------------------------------------------------------------
  // down-counter
  // ------------------------------------------------------------
  wut_downcnt u_downcnt (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ring_tick(ring_tick_q),
    .run(run_q),
    .start_value(start_q),
    .count_q(count_live),
    .done_q(count_done)
  );

  // the view register gives software one settled copy per cycle; the
  // counter may still step between two reads, hence the reread advice
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_view_q <= wut_pkg::VALUE_RST;
    end else begin
      count_view_q <= count_live;
    end
  end

  // ------------------------------------------------------------
  // done flag
  // ------------------------------------------------------------
  // a zero event in the same cycle as an enable change still sets the flag
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      done_flag_q <= 1'b0;
    end else if (count_done && run_q) begin
      done_flag_q <= 1'b1;
    end else if (run_change) begin
      done_flag_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupt status and mask
  // ------------------------------------------------------------
  always_comb begin
    irq_set = 8'h00;
    irq_set[wut_pkg::IRQ_DONE_BIT] = count_done && run_q;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_status_q <= wut_pkg::IRQ_STATUS_RST;
    end else if (wr_hit_status && w_strb_q[0]) begin
      irq_status_q <= (irq_status_q & ~w_data_q[7:0]) | irq_set;
    end else begin
      irq_status_q <= irq_status_q | irq_set;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_q <= wut_pkg::IRQ_MASK_RST;
    end else if (wr_hit_mask && w_strb_q[0]) begin
      irq_mask_q <= w_data_q[7:0];
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_q;

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[wut_pkg::CTRL_RUN_BIT] = run_q;
    ctrl_rd[wut_pkg::CTRL_DONE_BIT] = done_flag_q;
  end

  assign value_rd = run_q ? count_view_q : start_q;

  always_comb begin
    rd_word = 32'h00000000;
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      wut_pkg::ADDR_CONTROL: begin
        rd_word[7:0] = ctrl_rd;
      end
      wut_pkg::ADDR_VALUE: begin
        rd_word[15:0] = value_rd;
      end
      wut_pkg::ADDR_IRQ_STATUS: begin
        rd_word[7:0] = irq_status_q;
      end
      wut_pkg::ADDR_IRQ_MASK: begin
        rd_word[7:0] = irq_mask_q;
      end
      default: begin
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= wut_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_mapped ? wut_pkg::RESP_OKAY : wut_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule
